// ===== design/flash_host.sv
// Purpose: host that runs erase-state evaluation and continuity check
// Assumes: one parallel flash on the pins, byte mode set by software
// Notes:   software port has read data one cycle after the read strobe
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps
module flash_host
	import flash_host_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// software register port
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWrData,
	input  wire logic        regWrEn,
	input  wire logic        regRdEn,
	output logic      [31:0] regRdData,
	output logic             irq,
	// flash pins
	output logic      [22:0] flashAddr,
	output logic      [15:0] dqOut,
	output logic             dqOe,
	input  wire logic [15:0] dqIn,
	output logic             ceN,
	output logic             oeN,
	output logic             weN,
	output logic             byteN
);

	// ------------------------------------------------------------
	// step table: {isRead, addr, data} for each step of each op
	// ------------------------------------------------------------
	function automatic logic [39:0] stepOf(input op_t op,
		input logic [3:0] step, input logic wide,
		input logic [22:0] sect);
		logic [22:0] cmdA;
		logic [39:0] r;
		cmdA = wide ? ADR_CMD_W : ADR_CMD_B;
		r    = {1'b0, cmdA, DAT_SREAD};
		if (op == OP_EVAL) begin
			case (step)
				4'h1, 4'h4: r = {1'b1, cmdA, 16'h0000};
				4'h2: r = {1'b0, sect, DAT_EVAL};
				default: r = {1'b0, cmdA, DAT_SREAD};
			endcase
		end else begin
			case (step)
				4'h0: r = {1'b0, cmdA, DAT_SCLR};
				4'h2, 4'h6: r = {1'b1, cmdA, 16'h0000};
				4'h3: r = wide ? {1'b0, ADR_PAT1_W, DAT_PAT1_W}
					: {1'b0, ADR_PAT1_B, DAT_PAT1_B};
				4'h4: r = wide ? {1'b0, ADR_PAT2_W, DAT_PAT2_W}
					: {1'b0, ADR_PAT2_B, DAT_PAT2_B};
				default: r = {1'b0, cmdA, DAT_SREAD};
			endcase
		end
		return r;
	endfunction : stepOf

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	seq_state_t           state_ff;
	op_t                  op_ff;
	logic [3:0]           step_ff;
	logic [5:0]           cnt_ff;
	logic                 wide_ff;
	logic [22:0]          sector_ff;
	logic [7:0]           word_ff;
	logic                 erased_ff;
	logic                 contPass_ff;
	logic [IRQ_W-1:0]     irqStat_ff;
	logic [IRQ_W-1:0]     irqMask_ff;
	logic [IRQ_W-1:0]     nxt_events;
	logic [15:0]          dqMeta_ff;
	logic [15:0]          dqSync_ff;
	logic                 readyOk_ff;
	logic [39:0]          cur;
	logic                 curRead;
	logic                 startEval;
	logic                 startCont;

	assign cur       = stepOf(op_ff, step_ff, wide_ff, sector_ff);
	assign curRead   = cur[39];
	assign startEval = regWrEn && regAddr == OFS_COMMAND
		&& regWrData[CMD_EVAL] && state_ff == S_IDLE;
	assign startCont = regWrEn && regAddr == OFS_COMMAND
		&& regWrData[CMD_CONT] && !regWrData[CMD_EVAL]
		&& state_ff == S_IDLE;

	// ------------------------------------------------------------
	// data pin synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dqMeta_ff <= 16'h0000;
			dqSync_ff <= 16'h0000;
		end else begin
			dqMeta_ff <= dqIn;
			dqSync_ff <= dqMeta_ff;
		end
	end

	// ------------------------------------------------------------
	// bus cycle sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= S_IDLE;
			op_ff    <= OP_NONE;
			step_ff  <= 4'h0;
			cnt_ff   <= 6'h00;
		end else begin
			case (state_ff)
				S_IDLE: begin
					step_ff <= 4'h0;
					cnt_ff  <= 6'(SETUP_CYC);
					if (startEval) begin
						op_ff    <= OP_EVAL;
						state_ff <= S_SETUP;
					end else if (startCont) begin
						op_ff    <= OP_CONT;
						state_ff <= S_SETUP;
					end
				end
				S_SETUP: begin
					cnt_ff <= cnt_ff - 6'h01;
					if (cnt_ff == 6'h01) begin
						cnt_ff   <= curRead ? 6'(RD_CYC) : 6'(WP_CYC);
						state_ff <= S_PULSE;
					end
				end
				S_PULSE: begin
					cnt_ff <= cnt_ff - 6'h01;
					if (cnt_ff == 6'h01) begin
						cnt_ff   <= 6'(WPH_CYC);
						state_ff <= S_RECOV;
					end
				end
				S_RECOV: begin
					cnt_ff <= cnt_ff - 6'h01;
					if (cnt_ff == 6'h01) begin
						state_ff <= S_NEXT;
					end
				end
				S_NEXT: begin
					cnt_ff   <= 6'(SETUP_CYC);
					state_ff <= S_SETUP;
					step_ff  <= step_ff + 4'h1;
					if (op_ff == OP_EVAL) begin
						if (step_ff == 4'h1 && !word_ff[SW_READY]) begin
							state_ff <= S_IDLE;
						end else if (step_ff == 4'h4) begin
							if (word_ff[SW_READY]) begin
								state_ff <= S_IDLE;
							end else begin
								step_ff <= 4'h3;
							end
						end
					end else begin
						if ((step_ff == 4'h2 && word_ff[SW_CONT])
							|| step_ff == 4'h6) begin
							state_ff <= S_IDLE;
						end
					end
				end
				default: state_ff <= S_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// flash pin drive
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			flashAddr <= 23'h000000;
			dqOut     <= 16'h0000;
			dqOe      <= 1'b0;
			ceN       <= 1'b1;
			oeN       <= 1'b1;
			weN       <= 1'b1;
		end else begin
			flashAddr <= cur[38:16];
			dqOut     <= cur[15:0];
			ceN       <= state_ff == S_IDLE;
			dqOe      <= !curRead && (state_ff == S_SETUP
				|| state_ff == S_PULSE || state_ff == S_RECOV);
			weN       <= !(state_ff == S_PULSE && !curRead);
			oeN       <= !(state_ff == S_PULSE && curRead);
		end
	end

	// status word captured at the end of each read pulse
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			word_ff <= 8'h00;
		end else if (state_ff == S_PULSE && curRead && cnt_ff == 6'h01) begin
			word_ff <= dqSync_ff[7:0];
		end
	end

	// device readiness seen before the evaluation command goes out
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			readyOk_ff <= 1'b0;
		end else if (state_ff == S_IDLE) begin
			readyOk_ff <= 1'b0;
		end else if (state_ff == S_NEXT && op_ff == OP_EVAL
			&& step_ff == 4'h1) begin
			readyOk_ff <= word_ff[SW_READY];
		end
	end

	// ------------------------------------------------------------
	// results and events
	// ------------------------------------------------------------
	always_comb begin
		nxt_events = '0;
		if (state_ff == S_NEXT) begin
			if (op_ff == OP_EVAL) begin
				if (step_ff == 4'h1 && !word_ff[SW_READY]) begin
					nxt_events[EV_REFUSED] = 1'b1;
				end
				if (step_ff == 4'h4 && word_ff[SW_READY]) begin
					nxt_events[EV_EVAL_DONE] = 1'b1;
					nxt_events[EV_NOT_ERASE] = word_ff[SW_ERRSTAT];
				end
			end else begin
				if (step_ff == 4'h2 && word_ff[SW_CONT]) begin
					nxt_events[EV_CONT_DONE] = 1'b1;
					nxt_events[EV_CONT_FAIL] = 1'b1;
				end
				if (step_ff == 4'h6) begin
					nxt_events[EV_CONT_DONE] = 1'b1;
					nxt_events[EV_CONT_FAIL] = !word_ff[SW_CONT];
				end
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			erased_ff   <= 1'b0;
			contPass_ff <= 1'b0;
		end else begin
			if (nxt_events[EV_EVAL_DONE]) begin
				erased_ff <= !word_ff[SW_ERRSTAT];
			end
			if (nxt_events[EV_CONT_DONE]) begin
				contPass_ff <= !nxt_events[EV_CONT_FAIL];
			end
		end
	end

	// ------------------------------------------------------------
	// software registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wide_ff    <= 1'b1;
			sector_ff  <= 23'h000000;
			irqMask_ff <= '0;
		end else if (regWrEn) begin
			case (regAddr)
				OFS_CONFIG:   if (state_ff == S_IDLE) begin
					wide_ff <= regWrData[CFG_WIDE];
				end
				OFS_SECTOR:   if (state_ff == S_IDLE) begin
					sector_ff <= regWrData[22:0];
				end
				OFS_IRQ_MASK: irqMask_ff <= regWrData[IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// sticky events, write one to clear, a new event beats the clear
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irqStat_ff <= '0;
		end else begin
			irqStat_ff <= (irqStat_ff & ~((regWrEn
				&& regAddr == OFS_IRQ_STAT) ? regWrData[IRQ_W-1:0]
				: '0)) | nxt_events;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq       <= 1'b0;
			byteN     <= 1'b1;
			regRdData <= 32'h00000000;
		end else begin
			irq   <= |(irqStat_ff & irqMask_ff);
			byteN <= wide_ff;
			if (regRdEn) begin
				case (regAddr)
					OFS_CONFIG:   regRdData <= {31'h0, wide_ff};
					OFS_SECTOR:   regRdData <= {9'h000, sector_ff};
					OFS_STATE:    regRdData <= {16'h0000, word_ff,
						5'h00, contPass_ff, erased_ff,
						state_ff != S_IDLE};
					OFS_IRQ_STAT: regRdData <= {27'h0, irqStat_ff};
					OFS_IRQ_MASK: regRdData <= {27'h0, irqMask_ff};
					default:      regRdData <= 32'h00000000;
				endcase
			end else begin
				regRdData <= 32'h00000000;
			end
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	chk_eval_cmd_addr: assert property (@(posedge clk) disable iff (!arst_n)
		$fell(weN) && dqOut == DAT_EVAL |-> flashAddr == sector_ff)
		else $error("evaluation command not at sector address");

	chk_eval_after_ready: assert property (@(posedge clk)
		disable iff (!arst_n)
		$fell(weN) && dqOut == DAT_EVAL |-> readyOk_ff)
		else $error("evaluation issued without device ready");

	chk_poll_ready: assert property (@(posedge clk) disable iff (!arst_n)
		nxt_events[EV_EVAL_DONE] |-> word_ff[SW_READY]
		&& op_ff == OP_EVAL ##1 state_ff == S_IDLE)
		else $error("result taken before ready");

	chk_reerase_flag: assert property (@(posedge clk) disable iff (!arst_n)
		nxt_events[EV_EVAL_DONE] && word_ff[SW_ERRSTAT]
		|=> irqStat_ff[EV_NOT_ERASE] && !erased_ff)
		else $error("not-erased sector not flagged");

	chk_wide_pattern: assert property (@(posedge clk) disable iff (!arst_n)
		$fell(weN) && wide_ff && flashAddr == ADR_PAT1_W
		|-> dqOut == DAT_PAT1_W && dqOe)
		else $error("wrong first 16-bit continuity word");

	chk_byte_pattern: assert property (@(posedge clk) disable iff (!arst_n)
		$fell(weN) && !wide_ff && flashAddr == ADR_PAT2_B
		|-> dqOut == DAT_PAT2_B && !byteN)
		else $error("wrong second 8-bit continuity byte");

endmodule : flash_host

// ===== design/flash_host_pkg.sv
// Purpose: constants for the flash erase-check and continuity host
// Assumes: 250 MHz clock, asynchronous parallel flash bus
// Notes:   all offsets, fields and timing counts live here
package flash_host_pkg;

	// ------------------------------------------------------------
	// software register map
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CONFIG   = 8'h00;
	localparam logic [7:0] OFS_COMMAND  = 8'h04;
	localparam logic [7:0] OFS_SECTOR   = 8'h08;
	localparam logic [7:0] OFS_STATE    = 8'h0c;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

	localparam int CFG_WIDE     = 0;
	localparam int CMD_EVAL     = 0;
	localparam int CMD_CONT     = 1;
	localparam int ST_BUSY      = 0;
	localparam int ST_ERASED    = 1;
	localparam int ST_CONT_PASS = 2;
	localparam int ST_WORD_LSB  = 8;
	localparam int IRQ_W        = 5;
	localparam int EV_EVAL_DONE = 0;
	localparam int EV_NOT_ERASE = 1;
	localparam int EV_CONT_DONE = 2;
	localparam int EV_CONT_FAIL = 3;
	localparam int EV_REFUSED   = 4;

	// ------------------------------------------------------------
	// device status word bits and command codes
	// ------------------------------------------------------------
	localparam int SW_READY   = 7;
	localparam int SW_ERRSTAT = 5;
	localparam int SW_CONT    = 0;

	localparam logic [15:0] DAT_EVAL  = 16'h0035;
	localparam logic [15:0] DAT_SREAD = 16'h0070;
	localparam logic [15:0] DAT_SCLR  = 16'h0071;

	localparam logic [22:0] ADR_CMD_W  = 23'h000555;
	localparam logic [22:0] ADR_CMD_B  = 23'h000aaa;
	localparam logic [22:0] ADR_PAT1_W = 23'h2aaa55;
	localparam logic [22:0] ADR_PAT2_W = 23'h1555aa;
	localparam logic [15:0] DAT_PAT1_W = 16'hff00;
	localparam logic [15:0] DAT_PAT2_W = 16'h00ff;
	localparam logic [22:0] ADR_PAT1_B = 23'h5554ab;
	localparam logic [22:0] ADR_PAT2_B = 23'h2aab54;
	localparam logic [15:0] DAT_PAT1_B = 16'h00ff;
	localparam logic [15:0] DAT_PAT2_B = 16'h0000;

	// ------------------------------------------------------------
	// bus timing
	// ------------------------------------------------------------
	localparam int CLK_NS    = 4;
	localparam int T_SETUP_NS = 4;
	localparam int T_WP_NS   = 35;
	localparam int T_WPH_NS  = 20;
	localparam int T_ACC_NS  = 70;
	localparam int SYNC_CYC  = 2;
	localparam int SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int WP_CYC    = (T_WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int WPH_CYC   = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
	localparam int RD_CYC    = (T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		S_IDLE  = 5'b00001,
		S_SETUP = 5'b00010,
		S_PULSE = 5'b00100,
		S_RECOV = 5'b01000,
		S_NEXT  = 5'b10000
	} seq_state_t;

	typedef enum logic [1:0] {
		OP_NONE = 2'h0,
		OP_EVAL = 2'h1,
		OP_CONT = 2'h2
	} op_t;

endpackage : flash_host_pkg

// ===== bench/flash_dev_model.sv
// Purpose: behavioural flash device on the far side of the host pins
// Assumes: host keeps ceN low through each sequence, no access delay
// Notes:   released DQ lines show the inverse of the last driven word
`timescale 1ns/1ps
module flash_dev_model #(
	parameter int EVAL_NS = 2000,
	parameter int HALT_NS = 600
) (
	// flash pins
	input  wire logic        ceN,
	input  wire logic        oeN,
	input  wire logic        weN,
	input  wire logic        byteN,
	input  wire logic [22:0] flashAddr,
	input  wire logic [15:0] dqOut,
	output logic      [15:0] dqIn,
	// bench controls
	input  wire logic        notErased,
	input  wire logic        devBusy,
	input  wire logic        badWire,
	input  wire logic        stuckCont,
	output int               evalSeen
);
	logic [7:0]  statusWord = 8'h80;
	logic        statMode = 1'b0;
	logic        prevPat = 1'b0;
	logic        isCmd;
	logic        pat1;
	logic        pat2;
	logic [15:0] d;
	logic [7:0]  statusOut;
	event        evalGo;

	initial evalSeen = 0;
	initial dqIn = 16'h0000;
	// stuckCont holds the shown continuity bit high, like a stuck pin
	assign statusOut = {statusWord[7] & ~devBusy, statusWord[6:1],
		statusWord[0] | stuckCont};

	// ------------------------------------------------------------
	// write decode on the rising write pulse
	// ------------------------------------------------------------
	always @(posedge weN) if (!ceN) begin
		d = byteN ? dqOut : {8'h00, dqOut[7:0]};
		isCmd = byteN ? (flashAddr[21:0] == 22'h000555)
			: (flashAddr == 23'h000aaa);
		pat1 = byteN ? (flashAddr[21:0] == 22'h2aaa55 && d == 16'hff00)
			: (flashAddr == 23'h5554ab && d[7:0] == 8'hff);
		pat2 = byteN ? (flashAddr[21:0] == 22'h1555aa && d == 16'h00ff)
			: (flashAddr == 23'h2aab54 && d[7:0] == 8'h00);
		if (prevPat && pat2 && !badWire)
			statusWord[0] = 1'b1;
		prevPat = pat1;
		if (isCmd && d[7:0] == 8'h70)
			statMode = 1'b1;
		else if (isCmd && d[7:0] == 8'h71) begin
			statusWord[0] = 1'b0;
			statusWord[5] = 1'b0;
		end else if (d[7:0] == 8'h35) begin
			// every 35h write is counted, accepted or not
			evalSeen++;
			if (statusOut[7]) begin
				statusWord[7] = 1'b0;
				->evalGo;
			end
		end
	end

	// a failing sector halts the scan early
	always @(evalGo) begin
		#(notErased ? HALT_NS : EVAL_NS);
		statusWord[5] = notErased;
		statusWord[7] = 1'b1;
	end

	// ------------------------------------------------------------
	// read data: status once after 70h, junk array while busy
	// ------------------------------------------------------------
	always @(negedge oeN) if (!ceN)
		dqIn = statMode ? {8'h00, statusOut}
			: (statusWord[7] ? 16'hffff : 16'h5a3c);
	always @(posedge oeN) begin
		statMode = 1'b0;
		dqIn = ~dqIn;
	end
endmodule : flash_dev_model

// ===== bench/tb.sv
// Purpose: self-checking bench for the flash erase-check host
// Assumes: flash_dev_model on the pins, register port by tasks
// Notes:   ordinary cases are table rows, odd cases follow
`timescale 1ns/1ps
module tb
	import flash_host_pkg::*;
;
	typedef struct packed {
		logic        wide;
		logic        cont;
		logic        notErased;
		logic        badWire;
		logic [15:0] expState;
		logic [15:0] mask;
		logic [4:0]  expIrq;
	} row_t;
	row_t rows [7] = '{
		'{1'b1, 1'b0, 1'b0, 1'b0, 16'h8002, 16'hff03, 5'h01},
		'{1'b1, 1'b0, 1'b1, 1'b0, 16'ha000, 16'hff03, 5'h03},
		'{1'b1, 1'b1, 1'b0, 1'b0, 16'h8104, 16'hff05, 5'h04},
		'{1'b0, 1'b1, 1'b0, 1'b0, 16'h8104, 16'hff05, 5'h04},
		'{1'b1, 1'b1, 1'b0, 1'b1, 16'h8000, 16'hff05, 5'h0c},
		'{1'b0, 1'b0, 1'b0, 1'b0, 16'h8002, 16'hff03, 5'h01},
		'{1'b0, 1'b1, 1'b0, 1'b1, 16'h8000, 16'hff05, 5'h0c}};
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [7:0]  regAddr = 8'h00;
	logic [31:0] regWrData = 32'h0;
	logic        regWrEn = 1'b0;
	logic        regRdEn = 1'b0;
	logic [31:0] regRdData;
	logic        irq;
	logic [22:0] flashAddr;
	logic [15:0] dqOut;
	logic        dqOe;
	logic [15:0] dqIn;
	logic        ceN;
	logic        oeN;
	logic        weN;
	logic        byteN;
	logic        notErased = 1'b0;
	logic        devBusy = 1'b0;
	logic        badWire = 1'b0;
	logic        stuckCont = 1'b0;
	int          evalSeen;
	int          bad_count = 0;
	int          checked = 0;
	int          cycles = 0;
	logic [31:0] d;
	int          n0;

	always #2 clk = ~clk;

	flash_host u_dut (.clk(clk), .arst_n(arst_n), .regAddr(regAddr),
		.regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regRdData(regRdData), .irq(irq), .flashAddr(flashAddr),
		.dqOut(dqOut), .dqOe(dqOe), .dqIn(dqIn), .ceN(ceN), .oeN(oeN),
		.weN(weN), .byteN(byteN));
	flash_dev_model u_dev (.ceN(ceN), .oeN(oeN), .weN(weN),
		.byteN(byteN), .flashAddr(flashAddr), .dqOut(dqOut), .dqIn(dqIn),
		.notErased(notErased), .devBusy(devBusy), .badWire(badWire),
		.stuckCont(stuckCont), .evalSeen(evalSeen));

	// ------------------------------------------------------------
	// bus and compare tasks
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		regAddr <= a;
		regWrData <= v;
		regWrEn <= 1'b1;
		@(posedge clk);
		regWrEn <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge clk);
		regRdEn <= 1'b0;
		#1 v = regRdData;
	endtask : rd
	task automatic cmpReg(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmpReg
	task automatic cmpBit(input logic got, input logic exp);
		cmpReg({31'h0, got}, {31'h0, exp});
	endtask : cmpBit
	task automatic waitIdle;
		logic [31:0] s;
		int n;
		s = 32'h1;
		n = 0;
		while (s[ST_BUSY] !== 1'b0 && n < 400) begin
			rd(OFS_STATE, s);
			n++;
		end
		cmpBit(s[ST_BUSY], 1'b0);
	endtask : waitIdle
	task automatic summarize;
		if (bad_count == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize

	always @(posedge clk) begin
		cycles++;
		if (cycles == 80000) begin
			bad_count++;
			summarize();
		end
	end

	initial begin
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			notErased = rows[i].notErased;
			badWire = rows[i].badWire;
			wr(OFS_CONFIG, {31'h0, rows[i].wide});
			wr(OFS_SECTOR, 32'h0010_0000);
			wr(OFS_COMMAND, rows[i].cont ? 32'h2 : 32'h1);
			waitIdle();
			rd(OFS_STATE, d);
			cmpReg(d & rows[i].mask, rows[i].expState);
			rd(OFS_IRQ_STAT, d);
			cmpReg(d, {27'h0, rows[i].expIrq});
			wr(OFS_IRQ_STAT, 32'h1f);
		end
		// second reset: register reset values
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		rd(OFS_CONFIG, d);
		cmpReg(d, 32'h1);
		cmpBit(ceN & oeN & weN & byteN & !dqOe, 1'b1);
		rd(OFS_IRQ_MASK, d);
		cmpReg(d, 32'h0);
		rd(8'h20, d);
		cmpReg(d, 32'h0);
		// device not in standby: no 35h written
		devBusy = 1'b1;
		n0 = evalSeen;
		wr(OFS_COMMAND, 32'h1);
		waitIdle();
		cmpBit(evalSeen == n0, 1'b1);
		rd(OFS_IRQ_STAT, d);
		cmpReg(d, 32'h10);
		wr(OFS_IRQ_STAT, 32'h1f);
		devBusy = 1'b0;
		// orders during a running evaluation are ignored
		notErased = 1'b0;
		n0 = evalSeen;
		wr(OFS_COMMAND, 32'h1);
		wr(OFS_COMMAND, 32'h2);
		wr(OFS_CONFIG, 32'h0);
		rd(OFS_STATE, d);
		cmpBit(d[ST_BUSY], 1'b1);
		waitIdle();
		cmpBit(evalSeen == n0 + 1, 1'b1);
		rd(OFS_CONFIG, d);
		cmpReg(d, 32'h1);
		rd(OFS_IRQ_STAT, d);
		cmpReg(d, 32'h01);
		// interrupt masked, raised, cleared
		cmpBit(irq, 1'b0);
		wr(OFS_IRQ_MASK, 32'h01);
		repeat (2) @(posedge clk);
		cmpBit(irq, 1'b1);
		wr(OFS_IRQ_STAT, 32'h01);
		repeat (2) @(posedge clk);
		cmpBit(irq, 1'b0);
		// status bit zero stuck high: check stops after the first read
		stuckCont = 1'b1;
		wr(OFS_IRQ_MASK, 32'h08);
		wr(OFS_COMMAND, 32'h2);
		waitIdle();
		rd(OFS_STATE, d);
		cmpReg(d & 32'hff05, 32'h8100);
		rd(OFS_IRQ_STAT, d);
		cmpReg(d, 32'h0c);
		cmpBit(irq, 1'b1);
		stuckCont = 1'b0;
		summarize();
	end
endmodule : tb
